// ==== dv/batt_adc_model.sv ====
// Purpose: battery converter model on the far side of the measure port
// Assumes: a request is a one-cycle pulse; the answer is a one-cycle pulse
// Notes: data lines toggle outside the answer cycle so stale values never match
`timescale 1ns/100ps
module batt_adc_model (
  // clock
  input wire logic clk,
  // conversion handshake
  input wire logic req,
  output logic done,
  output logic [15:0] mv,
  // answer delay and level set by the bench
  input wire logic [7:0] delay,
  input wire logic [15:0] level
);
  logic busy_q;
  logic [7:0] cnt_q;
  initial begin
    done = 1'b0;
    mv = 16'h0000;
    busy_q = 1'b0;
    cnt_q = 8'h00;
  end
  // one conversion at a time; a request while busy is lost, as on a real converter
  always @(posedge clk) begin
    done <= 1'b0;
    mv <= ~mv;
    if (busy_q) begin
      if (cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        done <= 1'b1;
        mv <= level;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end else if (req) begin
      busy_q <= 1'b1;
      cnt_q <= delay;
    end
  end
endmodule // batt_adc_model

// ==== dv/smart_lock_event_controller_bench.sv ====
// Purpose: self-checking bench of the lock event controller
// Assumes: short timer parameters; battery converter model on the measure port
// Notes: inputs move on the falling edge; timing windows allow one tick of phase slack
`timescale 1ns/100ps
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module smart_lock_event_controller_bench;
  localparam int TK = 4;
  localparam int ADV = 10;
  localparam int BAT = 50;
  localparam int IDL = 20;
  localparam int MOT = 3;
  localparam int ANI = 4;
  localparam int TST = 10;
  localparam int SHW = 3;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic CONNECT = 1'b0;
  logic DISCONNECT = 1'b0;
  logic LINK_ACTIVITY = 1'b0;
  logic WR_VALID = 1'b0;
  logic [7:0] WR_DATA = 8'h00;
  logic [2:0] BUTTON = 3'h0;
  logic FAULTN = 1'b1;
  logic ADV_REQ, DROP_LINK, CONN_CHANGE, CONNECTED, BATT_REQ, BATT_DONE, DRV_SLEEPN, LED_ENABLE, AWAKE;
  logic [7:0] LOCK_STATE, MOTOR_DUTY;
  logic [15:0] BATT_MV;
  lock_ctrl_pkg::mot_dir_t MOTOR_DIR;
  lock_ctrl_pkg::led_pat_t LED_PATTERN;
  logic [7:0] adc_delay = 8'h02;
  logic [15:0] adc_level = 16'h1388;
  int seed = 69;
  int num_errors = 0;
  int checked = 0;
  int batt_n = 0;

  // 250 MHz clock
  always #2 CLK = ~CLK;

  lock_event_ctrl #(.TICK_CYC(TK), .ADV_MS(ADV), .BATT_MS(BAT), .IDLE_MS(IDL), .MOTOR_MS(MOT),
    .ANIM_MS(ANI), .TEST_MS(TST), .SHOW_MS(SHW)) lock_event_ctrl_i (.CLK(CLK), .RESETN(RESETN),
    .CONNECT(CONNECT), .DISCONNECT(DISCONNECT), .LINK_ACTIVITY(LINK_ACTIVITY), .WR_VALID(WR_VALID),
    .WR_DATA(WR_DATA), .ADV_REQ(ADV_REQ), .DROP_LINK(DROP_LINK), .CONN_CHANGE(CONN_CHANGE),
    .CONNECTED(CONNECTED), .LOCK_STATE(LOCK_STATE), .BATT_REQ(BATT_REQ), .BATT_DONE(BATT_DONE),
    .BATT_MV(BATT_MV), .BUTTON(BUTTON), .FAULTN(FAULTN), .DRV_SLEEPN(DRV_SLEEPN),
    .LED_ENABLE(LED_ENABLE), .MOTOR_DIR(MOTOR_DIR), .MOTOR_DUTY(MOTOR_DUTY),
    .LED_PATTERN(LED_PATTERN), .AWAKE(AWAKE));

  batt_adc_model batt_adc_model_i (.clk(CLK), .req(BATT_REQ), .done(BATT_DONE), .mv(BATT_MV),
    .delay(adc_delay), .level(adc_level));

  // count conversion requests so quiet spans can be proven quiet
  always @(posedge CLK) if (BATT_REQ === 1'b1) batt_n++;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic sel(input int w);
    case (w)
      0: return ADV_REQ === 1'b1;
      1: return BATT_REQ === 1'b1;
      2: return DROP_LINK === 1'b1;
      3: return CONN_CHANGE === 1'b1;
      4: return MOTOR_DIR !== lock_ctrl_pkg::MOT_COAST;
      5: return AWAKE === 1'b0;
      default: return LED_PATTERN === lock_ctrl_pkg::LED_COLOURS;
    endcase
  endfunction
  function automatic logic rng(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  // duty that brings the motor to 4 V, full drive when the battery is at or below it
  function automatic logic [7:0] exp_duty(input int mv);
    return mv <= 4000 ? 8'hff : 8'(4000 * 255 / mv);
  endfunction
  function automatic int rnd(input int lo, input int span);
    return lo + int'($unsigned($random(seed)) % span);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // bounded wait; n is the count of falling edges passed
  task automatic wait_sig(input int w, input int lim, output int n);
    n = 0;
    while (!sel(w) && n < lim) begin
      @(negedge CLK);
      n++;
    end
  endtask
  task automatic hit(input int w);
    {LINK_ACTIVITY, DISCONNECT, CONNECT} = 3'(1 << w);
    tick(1);
    {LINK_ACTIVITY, DISCONNECT, CONNECT} = 3'h0;
  endtask
  task automatic btn(input int b);
    BUTTON = 3'(1 << b);
    tick(1);
    BUTTON = 3'h0;
  endtask
  task automatic run_len(output int n);
    n = 0;
    while (sel(4) && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  task automatic note(input string s);
    $display("test %s ended, errors %0d", s, num_errors);
  endtask
  // one lock-state write through to the end of its animation
  task automatic cmd(input logic [7:0] v, input int mv, input lock_ctrl_pkg::mot_dir_t dir,
    input lock_ctrl_pkg::led_pat_t led);
    int n;
    int m;
    adc_level = 16'(mv);
    adc_delay = 8'(rnd(0, 12));
    WR_VALID = 1'b1;
    WR_DATA = v;
    tick(1);
    WR_VALID = 1'b0;
    tick(1);
    `CHECK(LOCK_STATE, v) // state stored
    wait_sig(1, 8, n);
    `CHECK(BATT_REQ, 1'b1) // measure first
    wait_sig(4, 30, n);
    `CHECK(MOTOR_DIR, dir) // direction
    `CHECK(MOTOR_DUTY, exp_duty(mv)) // duty for 4 V
    `CHECK(LED_PATTERN, led) // animation
    run_len(n);
    `CHECK(rng(n, (MOT - 1) * TK + 1, MOT * TK + 1), 1'b1) // run time
    m = n;
    while (LED_PATTERN === led && m < 100) begin
      tick(1);
      m++;
    end
    `CHECK(rng(m, (ANI - 1) * TK + 1, ANI * TK + 1), 1'b1) // animation time
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    int b0;
    logic [7:0] d;
    tick(19);
    `CHECK({DRV_SLEEPN, LED_ENABLE}, 2'b11) // drivers held awake in reset
    tick(1);
    RESETN = 1'b1;
    tick(3);
    `CHECK({DRV_SLEEPN, LED_ENABLE}, 2'b00) // drivers asleep
    `CHECK(MOTOR_DIR, lock_ctrl_pkg::MOT_COAST) // motor idle
    note("reset");
    wait_sig(0, 60, n);
    tick(1);
    wait_sig(0, 60, n);
    `CHECK(n + 1, ADV * TK) // advert period
    note("advertise");
    adc_level = 16'h0fa0;
    wait_sig(1, 260, n);
    tick(12);
    `CHECK(LED_PATTERN === lock_ctrl_pkg::LED_RED_FLASH, 1'b0) // 4 V is not low
    adc_level = 16'(rnd(3000, 1000));
    wait_sig(1, 260, n);
    `CHECK(rng(n + 12, BAT * TK - 4, BAT * TK + 4), 1'b1) // sample period
    tick(12);
    `CHECK(LED_PATTERN, lock_ctrl_pkg::LED_RED_FLASH) // low battery
    wait_sig(5, 60, n);
    `CHECK(AWAKE, 1'b0) // back to standby
    note("battery");
    btn(0);
    wait_sig(6, 6, n);
    `CHECK(LED_PATTERN, lock_ctrl_pkg::LED_COLOURS) // colour show
    wait_sig(5, 60, n);
    btn(1);
    wait_sig(4, 6, n);
    `CHECK(MOTOR_DIR, lock_ctrl_pkg::MOT_FWD) // forward
    tick(8);
    btn(1);
    run_len(n);
    `CHECK(n <= 3, 1'b1) // second press stops
    wait_sig(5, 60, n);
    btn(2);
    wait_sig(4, 6, n);
    `CHECK(MOTOR_DIR, lock_ctrl_pkg::MOT_REV) // reverse
    run_len(n);
    `CHECK(rng(n, (TST - 1) * TK - 2, TST * TK + 2), 1'b1) // run limit
    wait_sig(5, 60, n);
    btn(1);
    wait_sig(4, 6, n);
    tick(4);
    FAULTN = 1'b0;
    tick(1);
    FAULTN = 1'b1;
    tick(3);
    `CHECK(LED_PATTERN, lock_ctrl_pkg::LED_YELLOW_PULSE) // fault shown
    tick(30);
    `CHECK(MOTOR_DIR, lock_ctrl_pkg::MOT_COAST) // no retry
    note("buttons");
    wait_sig(5, 60, n);
    hit(0);
    wait_sig(3, 4, n);
    `CHECK(CONN_CHANGE, 1'b1) // connect reported
    tick(1);
    `CHECK(CONNECTED, 1'b1) // link up
    btn(1);
    tick(6);
    `CHECK(MOTOR_DIR, lock_ctrl_pkg::MOT_COAST) // button ignored
    d = 8'(rnd(2, 254));
    b0 = batt_n;
    WR_VALID = 1'b1;
    WR_DATA = d;
    tick(1);
    WR_VALID = 1'b0;
    tick(10);
    `CHECK(LOCK_STATE, 8'h00) // invalid dropped
    `CHECK(batt_n, b0) // no action
    cmd(lock_ctrl_pkg::VAL_LOCK, rnd(3000, 3000), lock_ctrl_pkg::MOT_REV, lock_ctrl_pkg::LED_BLUE_CCW);
    cmd(lock_ctrl_pkg::VAL_UNLOCK, rnd(4001, 2000), lock_ctrl_pkg::MOT_FWD, lock_ctrl_pkg::LED_GREEN_CW);
    // a driver fault just after a command starts cuts the run and shows yellow
    WR_VALID = 1'b1;
    WR_DATA = lock_ctrl_pkg::VAL_LOCK;
    tick(1);
    WR_VALID = 1'b0;
    wait_sig(4, 30, n);
    FAULTN = 1'b0;
    tick(1);
    FAULTN = 1'b1;
    `CHECK(MOTOR_DIR, lock_ctrl_pkg::MOT_COAST) // run cut short
    `CHECK(LED_PATTERN, lock_ctrl_pkg::LED_YELLOW_PULSE) // fault shown
    wait_sig(5, 60, n);
    b0 = batt_n;
    repeat (8) begin
      hit(2);
      tick(29);
    end
    `CHECK(batt_n, b0) // monitor halted while linked
    hit(2);
    wait_sig(2, 120, n);
    `CHECK(rng(n, (IDL - 1) * TK, IDL * TK + 2), 1'b1) // idle drop time
    wait_sig(3, 4, n);
    `CHECK(CONN_CHANGE, 1'b1) // change raised
    tick(2);
    `CHECK(CONNECTED, 1'b0) // link down
    wait_sig(0, ADV * TK + 4, n);
    `CHECK(ADV_REQ, 1'b1) // adverts resume
    wait_sig(1, BAT * TK + 8, n);
    `CHECK(BATT_REQ, 1'b1) // monitor resumes
    note("timeout");
    wait_sig(5, 60, n);
    hit(0);
    tick(4);
    hit(1);
    tick(3);
    `CHECK(CONNECTED, 1'b0) // user drop
    wait_sig(1, BAT * TK + 8, n);
    `CHECK(BATT_REQ, 1'b1) // monitor resumes
    note("disconnect");
    report_and_stop;
  end

  // hang guard, well beyond the roughly 1500 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    report_and_stop;
  end
endmodule // smart_lock_event_controller_bench

// ==== verilog/lock_ctrl_pkg.sv ====
// Purpose: constants shared by the lock event controller
// Assumes: 250 MHz system clock, one tick enable of 1 ms derived inside the block
// Notes: Operation list below names each behaviour kept by the controller
//
// Operation
// - after reset, put LED and motor drivers into lowest power first
// - advertise once every 500 ms while unconnected
// - sample battery once per hour while waiting for a connection
// - on connect, stop battery monitoring and start the inactivity timer
// - force disconnect after 30 s without connection activity
// - any disconnect restarts periodic battery monitoring
// - invalid lock-state writes are dropped with no effect
// - valid lock-state write is stored and restarts the inactivity timer
// - measure battery and set motor duty for 4 V before each command run
// - lock runs motor reverse 1.8 s, blue LEDs counter-clockwise 2 s
// - unlock runs motor forward 1.8 s, green LEDs clockwise 2 s
// - on timeout, disconnect, resume advertising, raise connection-change event
// - ignore all test buttons while connected; a second press still stops a test run started before connecting
// - button one while unconnected shows a colour sequence
// - button two runs motor forward until pressed again, at most 10 s
// - button three runs motor reverse until pressed again, at most 10 s
// - periodic battery reading below 4 V flashes LEDs red
// - motor driver fault during a run pulses LEDs yellow, no retry
// - stay in standby, wake only to advertise, sample, or handle events
package lock_ctrl_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned ADV_MS = 500;
  localparam int unsigned BATT_MS = 3_600_000;
  localparam int unsigned IDLE_MS = 30_000;
  localparam int unsigned MOTOR_MS = 1800;
  localparam int unsigned ANIM_MS = 2000;
  localparam int unsigned TEST_MS = 10_000;
  localparam int unsigned SHOW_MS = 1000;
  // ---------------------------------------------------------------
  // lock values and analog scaling (battery code is millivolts)
  // ---------------------------------------------------------------
  localparam logic [7:0] VAL_LOCK = 8'h01;
  localparam logic [7:0] VAL_UNLOCK = 8'h00;
  localparam logic [15:0] MOTOR_MV = 16'h0fa0;
  localparam logic [15:0] LOW_BATT_MV = 16'h0fa0;
  localparam int unsigned DUTY_W = 8;
  // ---------------------------------------------------------------
  // LED patterns
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LED_OFF, LED_BLUE_CCW, LED_GREEN_CW, LED_COLOURS, LED_RED_FLASH, LED_YELLOW_PULSE
  } led_pat_t;
  typedef enum logic [1:0] {MOT_COAST, MOT_FWD, MOT_REV} mot_dir_t;
endpackage

// ==== verilog/lock_event_ctrl.sv ====
// Purpose: event driven controller of a battery powered lock
// Assumes: link layer, ADC and drivers are outside; all inputs synchronous to CLK
// Notes: one event is served at a time; a 1 ms tick drives every long timer
`timescale 1ns/100ps
module lock_event_ctrl #(
  parameter int unsigned TICK_CYC = lock_ctrl_pkg::TICK_CYC,
  parameter int unsigned ADV_MS = lock_ctrl_pkg::ADV_MS,
  parameter int unsigned BATT_MS = lock_ctrl_pkg::BATT_MS,
  parameter int unsigned IDLE_MS = lock_ctrl_pkg::IDLE_MS,
  parameter int unsigned MOTOR_MS = lock_ctrl_pkg::MOTOR_MS,
  parameter int unsigned ANIM_MS = lock_ctrl_pkg::ANIM_MS,
  parameter int unsigned TEST_MS = lock_ctrl_pkg::TEST_MS,
  parameter int unsigned SHOW_MS = lock_ctrl_pkg::SHOW_MS
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // link
  input wire logic CONNECT,
  input wire logic DISCONNECT,
  input wire logic LINK_ACTIVITY,
  input wire logic WR_VALID,
  input wire logic [7:0] WR_DATA,
  output logic ADV_REQ,
  output logic DROP_LINK,
  output logic CONN_CHANGE,
  output logic CONNECTED,
  output logic [7:0] LOCK_STATE,
  // battery converter
  output logic BATT_REQ,
  input wire logic BATT_DONE,
  input wire logic [15:0] BATT_MV,
  // buttons, one-cycle press pulses
  input wire logic [2:0] BUTTON,
  // drivers
  input wire logic FAULTN,
  output logic DRV_SLEEPN,
  output logic LED_ENABLE,
  output lock_ctrl_pkg::mot_dir_t MOTOR_DIR,
  output logic [7:0] MOTOR_DUTY,
  output lock_ctrl_pkg::led_pat_t LED_PATTERN,
  output logic AWAKE
);
  // refuse timings the counters cannot hold; the animation must outlast the motor run
  if (TICK_CYC < 2 || TICK_CYC > 262144 || ADV_MS < 1 || ADV_MS > 1024 || BATT_MS < 1 || BATT_MS > 4194304
      || IDLE_MS < 1 || IDLE_MS > 32768 || MOTOR_MS < 1 || MOTOR_MS >= ANIM_MS || ANIM_MS > 16384
      || TEST_MS < 1 || TEST_MS > 16384 || SHOW_MS < 1 || SHOW_MS > 16384) begin : g_bad_timing
    $error("lock_event_ctrl: bad timing parameters");
  end
  typedef enum logic [3:0] {
    ST_INIT, ST_IDLE, ST_BATT, ST_CMD_MEAS, ST_CMD_RUN, ST_TEST_RUN, ST_SHOW
  } state_t;
  state_t state_q;
  logic [17:0] tick_cnt_q;
  logic [9:0] adv_cnt_q;
  logic [21:0] batt_cnt_q;
  logic [14:0] idle_cnt_q;
  logic [13:0] run_cnt_q;
  logic [7:0] pend_val_q;
  logic [1:0] test_btn_q;
  logic tick, conn_q, batt_due_q, lock_pend_q, fault_seen_q, low_batt_q, valid_wr, timeout;
  // ---------------------------------------------------------------
  // tick divider
  // ---------------------------------------------------------------
  // one enable per millisecond keeps every long timer narrow
  always_ff @(posedge CLK) begin
    if (!RESETN || tick_cnt_q == 18'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
    end
  end
  assign tick = (tick_cnt_q == 18'(TICK_CYC - 1));

  function automatic logic [7:0] duty_for(input logic [15:0] mv);
    logic [23:0] q;
    q = '0;
    if (mv <= lock_ctrl_pkg::MOTOR_MV) begin
      duty_for = 8'hff;
    end else begin
      q = ({8'h00, lock_ctrl_pkg::MOTOR_MV} * 24'h0000ff) / {8'h00, mv};
      duty_for = q[7:0];
    end
  endfunction

  assign valid_wr = WR_VALID && conn_q &&
    (WR_DATA == lock_ctrl_pkg::VAL_LOCK || WR_DATA == lock_ctrl_pkg::VAL_UNLOCK);
  assign timeout = conn_q && tick && idle_cnt_q == 15'(IDLE_MS - 1);

  // ---------------------------------------------------------------
  // connection and inactivity timer
  // ---------------------------------------------------------------
  // activity or a valid write restart the timer; timeout drops the link
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      conn_q <= 1'b0;
      idle_cnt_q <= '0;
      DROP_LINK <= 1'b0;
      CONN_CHANGE <= 1'b0;
    end else begin
      DROP_LINK <= 1'b0;
      CONN_CHANGE <= 1'b0;
      if (!conn_q && CONNECT && state_q != ST_INIT) begin
        conn_q <= 1'b1;
        idle_cnt_q <= '0;
        CONN_CHANGE <= 1'b1;
      end else if (conn_q && (DISCONNECT || timeout)) begin
        conn_q <= 1'b0;
        idle_cnt_q <= '0; // a write in the drop cycle still leaves a restarted timer
        DROP_LINK <= timeout;
        CONN_CHANGE <= 1'b1;
      end else if (conn_q && (LINK_ACTIVITY || valid_wr)) begin
        idle_cnt_q <= '0;
      end else if (conn_q && tick) begin
        idle_cnt_q <= idle_cnt_q + 15'h0001;
      end
    end
  end
  // ---------------------------------------------------------------
  // advertising and battery period
  // ---------------------------------------------------------------
  // one advert per period; the count starts over after every disconnect
  always_ff @(posedge CLK) begin
    ADV_REQ <= 1'b0;
    if (!RESETN || conn_q || state_q == ST_INIT) begin
      adv_cnt_q <= '0;
    end else if (tick) begin
      if (adv_cnt_q == 10'(ADV_MS - 1)) begin
        adv_cnt_q <= '0;
        ADV_REQ <= 1'b1;
      end else begin
        adv_cnt_q <= adv_cnt_q + 10'h001;
      end
    end
  end
  // monitor stops while connected and starts over on any disconnect; the period
  // keeps running during a reading so a late answer never shifts the next one
  always_ff @(posedge CLK) begin
    if (!RESETN || conn_q || state_q == ST_INIT) begin
      batt_cnt_q <= '0;
      batt_due_q <= 1'b0;
    end else begin
      if (state_q == ST_BATT && BATT_DONE) begin
        batt_due_q <= 1'b0;
      end
      if (tick && batt_cnt_q == 22'(BATT_MS - 1)) begin
        batt_cnt_q <= '0;
        batt_due_q <= 1'b1; // a new period wins over the clear
      end else if (tick) begin
        batt_cnt_q <= batt_cnt_q + 22'h000001;
      end
    end
  end
  // ---------------------------------------------------------------
  // pending command latch
  // ---------------------------------------------------------------
  // one outstanding command; a later valid write replaces a waiting one
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      lock_pend_q <= 1'b0;
      pend_val_q <= lock_ctrl_pkg::VAL_UNLOCK;
      LOCK_STATE <= lock_ctrl_pkg::VAL_UNLOCK;
    end else if (valid_wr) begin
      lock_pend_q <= 1'b1; // set wins over the take below
      pend_val_q <= WR_DATA;
      LOCK_STATE <= WR_DATA;
    end else if (state_q == ST_IDLE) begin
      lock_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // event engine
  // ---------------------------------------------------------------
  // a single sequencer serves one event to completion; priority is command,
  // battery, then buttons, so a waiting command goes ahead of an earlier battery reading
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_q <= ST_INIT;
      run_cnt_q <= '0;
      test_btn_q <= '0;
      fault_seen_q <= 1'b0;
      low_batt_q <= 1'b0;
      DRV_SLEEPN <= 1'b1;
      LED_ENABLE <= 1'b1;
      MOTOR_DIR <= lock_ctrl_pkg::MOT_COAST;
      MOTOR_DUTY <= '0;
      LED_PATTERN <= lock_ctrl_pkg::LED_OFF;
      BATT_REQ <= 1'b0;
    end else begin
      BATT_REQ <= 1'b0;
      if (tick && state_q inside {ST_CMD_RUN, ST_TEST_RUN, ST_SHOW}) begin
        run_cnt_q <= run_cnt_q + 14'h0001;
      end
      unique case (state_q)
        ST_INIT: begin
          DRV_SLEEPN <= 1'b0;
          LED_ENABLE <= 1'b0;
          state_q <= ST_IDLE;
        end
        ST_IDLE: begin
          DRV_SLEEPN <= 1'b0;
          LED_ENABLE <= low_batt_q || fault_seen_q;
          MOTOR_DIR <= lock_ctrl_pkg::MOT_COAST;
          run_cnt_q <= '0;
          if (lock_pend_q) begin
            BATT_REQ <= 1'b1;
            state_q <= ST_CMD_MEAS;
          end else if (batt_due_q) begin
            BATT_REQ <= 1'b1;
            state_q <= ST_BATT;
          end else if (!conn_q && BUTTON[0]) begin
            LED_ENABLE <= 1'b1;
            LED_PATTERN <= lock_ctrl_pkg::LED_COLOURS;
            state_q <= ST_SHOW;
          end else if (!conn_q && (BUTTON[1] || BUTTON[2])) begin
            test_btn_q <= BUTTON[2:1];
            fault_seen_q <= 1'b0;
            DRV_SLEEPN <= 1'b1;
            MOTOR_DUTY <= 8'hff;
            MOTOR_DIR <= BUTTON[1] ? lock_ctrl_pkg::MOT_FWD : lock_ctrl_pkg::MOT_REV;
            state_q <= ST_TEST_RUN;
          end
        end
        ST_BATT: begin
          if (BATT_DONE) begin
            low_batt_q <= BATT_MV < lock_ctrl_pkg::LOW_BATT_MV;
            if (BATT_MV < lock_ctrl_pkg::LOW_BATT_MV) begin
              LED_ENABLE <= 1'b1;
              LED_PATTERN <= lock_ctrl_pkg::LED_RED_FLASH;
            end
            state_q <= ST_IDLE;
          end
        end
        ST_CMD_MEAS: begin
          if (BATT_DONE) begin
            MOTOR_DUTY <= duty_for(BATT_MV);
            DRV_SLEEPN <= 1'b1;
            LED_ENABLE <= 1'b1;
            fault_seen_q <= 1'b0;
            if (pend_val_q == lock_ctrl_pkg::VAL_LOCK) begin
              MOTOR_DIR <= lock_ctrl_pkg::MOT_REV;
              LED_PATTERN <= lock_ctrl_pkg::LED_BLUE_CCW;
            end else begin
              MOTOR_DIR <= lock_ctrl_pkg::MOT_FWD;
              LED_PATTERN <= lock_ctrl_pkg::LED_GREEN_CW;
            end
            state_q <= ST_CMD_RUN;
          end
        end
        ST_CMD_RUN: begin
          if (tick && run_cnt_q == 14'(MOTOR_MS - 1)) begin
            MOTOR_DIR <= lock_ctrl_pkg::MOT_COAST;
          end
          if (!FAULTN && MOTOR_DIR != lock_ctrl_pkg::MOT_COAST) begin
            fault_seen_q <= 1'b1;
            MOTOR_DIR <= lock_ctrl_pkg::MOT_COAST;
            LED_PATTERN <= lock_ctrl_pkg::LED_YELLOW_PULSE;
          end
          if (tick && run_cnt_q == 14'(ANIM_MS - 1)) begin
            if (!fault_seen_q) begin
              LED_PATTERN <= lock_ctrl_pkg::LED_OFF;
            end
            state_q <= ST_IDLE;
          end
        end
        ST_TEST_RUN: begin
          if ((tick && run_cnt_q == 14'(TEST_MS - 1)) || (BUTTON[2:1] & test_btn_q) != 2'b00) begin
            MOTOR_DIR <= lock_ctrl_pkg::MOT_COAST;
            state_q <= ST_IDLE;
          end else if (!FAULTN) begin
            fault_seen_q <= 1'b1;
            LED_ENABLE <= 1'b1;
            LED_PATTERN <= lock_ctrl_pkg::LED_YELLOW_PULSE;
            MOTOR_DIR <= lock_ctrl_pkg::MOT_COAST;
            state_q <= ST_IDLE;
          end
        end
        ST_SHOW: begin
          if (tick && run_cnt_q == 14'(SHOW_MS - 1)) begin
            LED_PATTERN <= lock_ctrl_pkg::LED_OFF;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign CONNECTED = conn_q;
  assign AWAKE = state_q != ST_IDLE || ADV_REQ;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_lowpower_first;
    @(posedge CLK) disable iff (!RESETN) state_q == ST_IDLE && $past(state_q == ST_INIT)
      |-> !DRV_SLEEPN && !LED_ENABLE;
  endproperty
  a_lowpower_first: assert property (p_lowpower_first) else $error("drivers not asleep after init");
  property p_no_adv_conn;
    @(posedge CLK) disable iff (!RESETN) conn_q && $past(conn_q) |-> !ADV_REQ;
  endproperty
  a_no_adv_conn: assert property (p_no_adv_conn) else $error("advertising while connected");
  property p_batt_stop;
    @(posedge CLK) disable iff (!RESETN) conn_q |=> batt_cnt_q == '0;
  endproperty
  a_batt_stop: assert property (p_batt_stop) else $error("battery timer runs while connected");
  property p_timeout_drop;
    @(posedge CLK) disable iff (!RESETN) timeout && !DISCONNECT |=> DROP_LINK && CONN_CHANGE && !conn_q;
  endproperty
  a_timeout_drop: assert property (p_timeout_drop) else $error("timeout did not drop link");
  property p_invalid_drop;
    @(posedge CLK) disable iff (!RESETN) WR_VALID && !valid_wr |=> LOCK_STATE == $past(LOCK_STATE);
  endproperty
  a_invalid_drop: assert property (p_invalid_drop) else $error("invalid write changed state");
  property p_valid_store;
    @(posedge CLK) disable iff (!RESETN) valid_wr |=> LOCK_STATE == $past(WR_DATA) && idle_cnt_q == '0;
  endproperty
  a_valid_store: assert property (p_valid_store) else $error("valid write not stored");
  property p_buttons_ignored;
    @(posedge CLK) disable iff (!RESETN) state_q == ST_IDLE && conn_q && !lock_pend_q && !batt_due_q
      |=> state_q == ST_IDLE;
  endproperty
  a_buttons_ignored: assert property (p_buttons_ignored) else $error("button served while connected");
  sequence s_meas_done;
    state_q == ST_CMD_MEAS && BATT_DONE;
  endsequence
  property p_cmd_start;
    @(posedge CLK) disable iff (!RESETN) s_meas_done |=> state_q == ST_CMD_RUN && MOTOR_DIR != lock_ctrl_pkg::MOT_COAST
      && MOTOR_DUTY == duty_for($past(BATT_MV));
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("command run not started right");
  property p_fault_yellow;
    @(posedge CLK) disable iff (!RESETN) state_q == ST_CMD_RUN && !FAULTN && MOTOR_DIR != lock_ctrl_pkg::MOT_COAST
      |=> LED_PATTERN == lock_ctrl_pkg::LED_YELLOW_PULSE && MOTOR_DIR == lock_ctrl_pkg::MOT_COAST;
  endproperty
  a_fault_yellow: assert property (p_fault_yellow) else $error("fault not shown");
endmodule // lock_event_ctrl
